// ### rtl/stepper_cfg_pkg.sv
/*
 * Shared constants and types for the step-motor power-up mode and
 * configuration block: switch positions, timing counts, register map and
 * the mode, range and resolution encodings.
 * Assumes a single 25 MHz system clock.
 */
`default_nettype none

package stepper_cfg_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLOCK_HZ = 25_000_000;
	localparam int SWITCH_SETTLE_US = 2000;
	localparam int SWITCH_SETTLE_CYCLES = SWITCH_SETTLE_US * (CLOCK_HZ / 1_000_000);
	localparam int CTRL_FILTER_NS = 200;
	localparam int CTRL_FILTER_CYCLES = (CTRL_FILTER_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;

	// ****************************************************************
	// Input bit positions in the raw pin vector
	// ****************************************************************
	localparam int SW_FIXED = 0;
	localparam int SW_RANGE_LO = 1;
	localparam int SW_RANGE_HI = 2;
	localparam int SW_CURRENT = 3;
	localparam int SW_MS_A = 4;
	localparam int SW_MS_B = 5;
	localparam int IN_ENABLE_N = 6;
	localparam int IN_STEP = 7;
	localparam int IN_DIR = 8;
	localparam int IN_START_N = 9;
	localparam int RAW_W = 10;
	localparam logic [9:0] RAW_IDLE = 10'h3c0;

	// ****************************************************************
	// Power-up switch codes, bits {current, range_hi, range_lo, fixed}
	// ****************************************************************
	localparam logic [3:0] BOOT_CURRENT = 4'h8;
	localparam logic [3:0] BOOT_RANGE = 4'h9;
	localparam logic [3:0] BOOT_FIXED = 4'h1;
	localparam logic [3:0] BOOT_NORMAL = 4'h0;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_POSITION = 4'h8;
	localparam int CTRL_SIXTEENTH_BIT = 0;
	localparam int CTRL_HOLD_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// ****************************************************************
	// Position increments in sixteenth-step units
	// ****************************************************************
	localparam logic [15:0] INC_FULL = 16'h0010;
	localparam logic [15:0] INC_HALF = 16'h0008;
	localparam logic [15:0] INC_QUARTER = 16'h0004;
	localparam logic [15:0] INC_EIGHTH = 16'h0002;
	localparam logic [15:0] INC_SIXTEENTH = 16'h0001;
	localparam logic [15:0] POSITION_RESET = 16'h0000;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		NO_MODE = 3'h0,
		CURRENT_SETUP_MODE = 3'h1,
		RANGE_SETUP_MODE = 3'h2,
		FIXED_FREQ_SETUP_MODE = 3'h3,
		STEP_DIR_DRIVER_MODE = 3'h4,
		ADJUSTABLE_FREQ_CTRL_MODE = 3'h5,
		FIXED_FREQ_CTRL_MODE = 3'h6,
		INVALID_MODE = 3'h7
	} op_mode_t;

	typedef enum logic [1:0] {
		STORED_STEP_DIR = 2'h0,
		STORED_ADJUSTABLE = 2'h1,
		STORED_FIXED = 2'h2,
		STORED_BLANK = 2'h3
	} normal_mode_t;

	typedef enum logic [1:0] {
		RANGE_RESERVED = 2'h0,
		LOW_FREQ_RANGE = 2'h1,
		MID_FREQ_RANGE = 2'h2,
		HIGH_FREQ_RANGE = 2'h3
	} freq_range_t;

	typedef enum logic [1:0] {
		RES_FINE = 2'h0,
		RES_HALF = 2'h1,
		RES_QUARTER = 2'h2,
		RES_FULL = 2'h3
	} resolution_t;

	typedef enum logic [2:0] {
		ST_BOOT = 3'h0,
		ST_SETUP = 3'h1,
		ST_RUN = 3'h2,
		ST_STORED = 3'h3,
		ST_INVALID = 3'h4
	} state_t;

	typedef struct packed {
		normal_mode_t mode;
		freq_range_t range;
	} store_t;

	typedef struct packed {
		logic start_active;
		logic motor_on;
		logic direction;
		resolution_t resolution;
		freq_range_t range;
		op_mode_t mode;
		state_t state;
	} status_t;

endpackage

`default_nettype wire

// ### rtl/stepper_powerup_mode_config.sv
/*
 * Power-up mode selection, setup sequencing, microstep decoding and step translation
 * for a single-axis step-motor driver, with a classic Wishbone register slave.
 * Assumes asynchronous switch pins (on = 1) and pulled-up active-low connector inputs,
 * a generator tick on the system clock, and a store that takes one-cycle requests.
 */
`default_nettype none

module stepper_powerup_mode_config #(
	parameter int SWITCH_SETTLE_CYCLES = stepper_cfg_pkg::SWITCH_SETTLE_CYCLES,
	parameter int CTRL_FILTER_CYCLES = stepper_cfg_pkg::CTRL_FILTER_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [5:0] i_config_switch,
	input wire logic i_drive_enable_n,
	input wire logic i_step_in,
	input wire logic i_direction_in,
	input wire logic i_start_stop_in,
	input wire logic i_gen_step_tick,
	input wire stepper_cfg_pkg::normal_mode_t i_stored_mode,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output logic o_motor_enable,
	output logic o_step_pulse,
	output logic o_direction,
	output stepper_cfg_pkg::resolution_t o_resolution,
	output stepper_cfg_pkg::op_mode_t o_mode,
	output stepper_cfg_pkg::freq_range_t o_gen_range,
	output logic o_gen_run,
	output logic o_store_valid,
	output stepper_cfg_pkg::store_t o_store
);
	// The latch waits out the two sync flops and the settle filter, or it would read idle switches.
	localparam int BOOT_WAIT = SWITCH_SETTLE_CYCLES + 3;
	localparam int CNT_W = $clog2(BOOT_WAIT + 1);

	// ************************************************************
	// Input synchronisers and filters
	// ************************************************************
	logic [9:0] raw;
	logic [9:0] clean;
	assign raw = {i_start_stop_in, i_direction_in, i_step_in, i_drive_enable_n, i_config_switch};

	for (genvar gi = 0; gi < stepper_cfg_pkg::RAW_W; gi++) begin : g_filter
		// Switches get a long settle time; connector inputs must pass 1 us step pulses.
		localparam int LIMIT = (gi < stepper_cfg_pkg::IN_ENABLE_N) ? SWITCH_SETTLE_CYCLES : CTRL_FILTER_CYCLES;
		logic meta_q, sync_q, clean_q, clean_d;
		logic [CNT_W-1:0] cnt_q, cnt_d;
		always_comb begin
			clean_d = clean_q;
			cnt_d = '0;
			if (sync_q != clean_q) begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(LIMIT - 1)) begin
					clean_d = sync_q;
					cnt_d = '0;
				end
			end
		end
		always_ff @(posedge i_clock) begin
			if (!i_rstn) begin
				meta_q <= stepper_cfg_pkg::RAW_IDLE[gi];
				sync_q <= stepper_cfg_pkg::RAW_IDLE[gi];
				clean_q <= stepper_cfg_pkg::RAW_IDLE[gi];
				cnt_q <= '0;
			end else begin
				meta_q <= raw[gi];
				sync_q <= meta_q;
				clean_q <= clean_d;
				cnt_q <= cnt_d;
			end
		end
		assign clean[gi] = clean_q;
	end
	// ************************************************************
	// Register, mode, setup and translator state
	// ************************************************************
	logic [1:0] ctrl_q, ctrl_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	stepper_cfg_pkg::status_t status;
	stepper_cfg_pkg::state_t state_q, state_d;
	stepper_cfg_pkg::op_mode_t mode_q, mode_d;
	stepper_cfg_pkg::freq_range_t range_q, range_d;
	stepper_cfg_pkg::resolution_t res_q, res_d;
	stepper_cfg_pkg::store_t store_q, store_d;
	logic [CNT_W-1:0] boot_cnt_q, boot_cnt_d;
	logic store_valid_q, store_valid_d, trig_prev_q, trig_prev_d, step_prev_q, step_prev_d, dir_q, dir_d;
	logic motor_q, motor_d, pulse_q, pulse_d, gen_run_q, gen_run_d;
	logic [15:0] pos_q, pos_d;
	logic [3:0] boot_code;
	logic step_rise, start_active, trigger, advance;
	logic [15:0] increment;

	assign boot_code = clean[3:0];
	assign step_rise = clean[stepper_cfg_pkg::IN_STEP] & ~step_prev_q;
	assign start_active = ~clean[stepper_cfg_pkg::IN_START_N];
	// Fixed-frequency setup is left through its own switch, the others through the current switch.
	assign trigger = (mode_q == stepper_cfg_pkg::FIXED_FREQ_SETUP_MODE) ?
		clean[stepper_cfg_pkg::SW_FIXED] : clean[stepper_cfg_pkg::SW_CURRENT];
	always_comb begin
		unique case (res_q)
			stepper_cfg_pkg::RES_FULL: increment = stepper_cfg_pkg::INC_FULL;
			stepper_cfg_pkg::RES_HALF: increment = stepper_cfg_pkg::INC_HALF;
			stepper_cfg_pkg::RES_QUARTER: increment = stepper_cfg_pkg::INC_QUARTER;
			stepper_cfg_pkg::RES_FINE: increment = ctrl_q[stepper_cfg_pkg::CTRL_SIXTEENTH_BIT] ?
				stepper_cfg_pkg::INC_SIXTEENTH : stepper_cfg_pkg::INC_EIGHTH;
		endcase
	end
	always_comb begin
		state_d = state_q;
		mode_d = mode_q;
		range_d = range_q;
		store_d = store_q;
		store_valid_d = 1'b0;
		boot_cnt_d = boot_cnt_q;
		trig_prev_d = trigger;
		// Microstep bits are read only after boot so they never affect mode decoding.
		res_d = (state_q == stepper_cfg_pkg::ST_BOOT) ? res_q :
			stepper_cfg_pkg::resolution_t'({clean[stepper_cfg_pkg::SW_MS_A], clean[stepper_cfg_pkg::SW_MS_B]});
		unique case (state_q)
			stepper_cfg_pkg::ST_BOOT: begin
				boot_cnt_d = boot_cnt_q + 1'b1;
				if (boot_cnt_q == CNT_W'(BOOT_WAIT)) begin
					state_d = stepper_cfg_pkg::ST_SETUP;
					unique case (boot_code)
						stepper_cfg_pkg::BOOT_CURRENT: mode_d = stepper_cfg_pkg::CURRENT_SETUP_MODE;
						stepper_cfg_pkg::BOOT_RANGE: mode_d = stepper_cfg_pkg::RANGE_SETUP_MODE;
						stepper_cfg_pkg::BOOT_FIXED: mode_d = stepper_cfg_pkg::FIXED_FREQ_SETUP_MODE;
						stepper_cfg_pkg::BOOT_NORMAL: begin
							state_d = stepper_cfg_pkg::ST_RUN;
							unique case (i_stored_mode)
								stepper_cfg_pkg::STORED_STEP_DIR: mode_d = stepper_cfg_pkg::STEP_DIR_DRIVER_MODE;
								stepper_cfg_pkg::STORED_ADJUSTABLE: mode_d = stepper_cfg_pkg::ADJUSTABLE_FREQ_CTRL_MODE;
								stepper_cfg_pkg::STORED_FIXED: mode_d = stepper_cfg_pkg::FIXED_FREQ_CTRL_MODE;
								stepper_cfg_pkg::STORED_BLANK: begin
									mode_d = stepper_cfg_pkg::INVALID_MODE;
									state_d = stepper_cfg_pkg::ST_INVALID;
								end
							endcase
						end
						default: begin
							mode_d = stepper_cfg_pkg::INVALID_MODE;
							state_d = stepper_cfg_pkg::ST_INVALID;
						end
					endcase
				end
			end
			stepper_cfg_pkg::ST_SETUP: begin
				if (mode_q == stepper_cfg_pkg::RANGE_SETUP_MODE) begin
					range_d = stepper_cfg_pkg::freq_range_t'(clean[2:1]);
				end
				if (trig_prev_q && !trigger) begin
					state_d = stepper_cfg_pkg::ST_STORED;
					store_valid_d = 1'b1;
					store_d.range = range_q;
					unique case (mode_q)
						stepper_cfg_pkg::CURRENT_SETUP_MODE: store_d.mode = clean[stepper_cfg_pkg::SW_FIXED] ?
							stepper_cfg_pkg::STORED_ADJUSTABLE : stepper_cfg_pkg::STORED_STEP_DIR;
						stepper_cfg_pkg::RANGE_SETUP_MODE: store_d.mode = clean[stepper_cfg_pkg::SW_FIXED] ?
							stepper_cfg_pkg::STORED_ADJUSTABLE : stepper_cfg_pkg::STORED_FIXED;
						default: store_d.mode = stepper_cfg_pkg::STORED_FIXED;
					endcase
				end
			end
			stepper_cfg_pkg::ST_RUN, stepper_cfg_pkg::ST_STORED, stepper_cfg_pkg::ST_INVALID: begin
			end
			default: state_d = stepper_cfg_pkg::ST_INVALID;
		endcase
	end
	always_comb begin
		step_prev_d = clean[stepper_cfg_pkg::IN_STEP];
		gen_run_d = 1'b0;
		advance = 1'b0;
		if (state_q == stepper_cfg_pkg::ST_RUN) begin
			unique case (mode_q)
				stepper_cfg_pkg::STEP_DIR_DRIVER_MODE: advance = step_rise;
				stepper_cfg_pkg::ADJUSTABLE_FREQ_CTRL_MODE, stepper_cfg_pkg::FIXED_FREQ_CTRL_MODE: begin
					gen_run_d = start_active;
					advance = i_gen_step_tick & gen_run_q;
				end
				default: advance = 1'b0;
			endcase
		end else if (state_q == stepper_cfg_pkg::ST_SETUP && mode_q == stepper_cfg_pkg::FIXED_FREQ_SETUP_MODE) begin
			gen_run_d = 1'b1;
			advance = i_gen_step_tick & gen_run_q;
		end
		advance = advance & ~ctrl_q[stepper_cfg_pkg::CTRL_HOLD_BIT];
		pulse_d = advance;
		dir_d = advance ? clean[stepper_cfg_pkg::IN_DIR] : dir_q;
		// Position keeps counting while drive is off, so re-enabling may show a position error.
		pos_d = !advance ? pos_q : (dir_d ? pos_q - increment : pos_q + increment);
		motor_d = ~clean[stepper_cfg_pkg::IN_ENABLE_N] &
			(state_q == stepper_cfg_pkg::ST_RUN || state_q == stepper_cfg_pkg::ST_SETUP);
	end
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			state_q <= stepper_cfg_pkg::ST_BOOT;
			mode_q <= stepper_cfg_pkg::NO_MODE;
			range_q <= stepper_cfg_pkg::RANGE_RESERVED;
			res_q <= stepper_cfg_pkg::RES_FINE;
			store_q <= '0;
			store_valid_q <= 1'b0;
			boot_cnt_q <= '0;
			trig_prev_q <= 1'b0;
			step_prev_q <= 1'b1;
			dir_q <= 1'b1;
			motor_q <= 1'b0;
			pulse_q <= 1'b0;
			gen_run_q <= 1'b0;
			pos_q <= stepper_cfg_pkg::POSITION_RESET;
		end else begin
			state_q <= state_d;
			mode_q <= mode_d;
			range_q <= range_d;
			res_q <= res_d;
			store_q <= store_d;
			store_valid_q <= store_valid_d;
			boot_cnt_q <= boot_cnt_d;
			trig_prev_q <= trig_prev_d;
			step_prev_q <= step_prev_d;
			dir_q <= dir_d;
			motor_q <= motor_d;
			pulse_q <= pulse_d;
			gen_run_q <= gen_run_d;
			pos_q <= pos_d;
		end
	end
	// ************************************************************
	// Wishbone slave
	// ************************************************************
	assign status = '{start_active: start_active, motor_on: motor_q, direction: dir_q, resolution: res_q,
		range: range_q, mode: mode_q, state: state_q};
	always_comb begin
		ctrl_d = ctrl_q;
		rdat_d = rdat_q;
		ack_d = i_wb_cyc & i_wb_stb & ~ack_q;
		if (ack_d) begin
			unique case (i_wb_adr)
				stepper_cfg_pkg::ADDR_CTRL: rdat_d = {30'h0, ctrl_q};
				stepper_cfg_pkg::ADDR_STATUS: rdat_d = {19'h0, status};
				stepper_cfg_pkg::ADDR_POSITION: rdat_d = {16'h0, pos_q};
				default: rdat_d = 32'h0;
			endcase
			if (i_wb_we && i_wb_sel[0] && i_wb_adr == stepper_cfg_pkg::ADDR_CTRL) begin
				ctrl_d = i_wb_dat[1:0];
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			ctrl_q <= stepper_cfg_pkg::CTRL_RESET;
			rdat_q <= 32'h0;
			ack_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			rdat_q <= rdat_d;
			ack_q <= ack_d;
		end
	end
	assign o_wb_dat = rdat_q;
	assign o_wb_ack = ack_q;
	assign o_motor_enable = motor_q;
	assign o_step_pulse = pulse_q;
	assign o_direction = dir_q;
	assign o_resolution = res_q;
	assign o_mode = mode_q;
	assign o_gen_range = range_q;
	assign o_gen_run = gen_run_q;
	assign o_store_valid = store_valid_q;
	assign o_store = store_q;
	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	sequence s_setup_exit;
		state_q == stepper_cfg_pkg::ST_SETUP && trig_prev_q && !trigger;
	endsequence
	sequence s_stored_forever;
		(state_q == stepper_cfg_pkg::ST_STORED) [*8];
	endsequence
	a_boot_decode: assert property ((state_q == stepper_cfg_pkg::ST_BOOT && boot_cnt_q == CNT_W'(BOOT_WAIT)
		&& boot_code == stepper_cfg_pkg::BOOT_RANGE) |=> mode_q == stepper_cfg_pkg::RANGE_SETUP_MODE)
		else $error("range setup code not decoded");
	a_range_track: assert property ((state_q == stepper_cfg_pkg::ST_SETUP && mode_q == stepper_cfg_pkg::RANGE_SETUP_MODE)
		|=> range_q == $past(clean[2:1]))
		else $error("range does not follow switches");
	a_res_decode: assert property (state_q != stepper_cfg_pkg::ST_BOOT |=> res_q == $past({clean[4], clean[5]}, 1))
		else $error("resolution not decoded");
	a_normal_boot: assert property ((state_q == stepper_cfg_pkg::ST_BOOT && boot_cnt_q == CNT_W'(BOOT_WAIT)
		&& boot_code == stepper_cfg_pkg::BOOT_NORMAL && i_stored_mode == stepper_cfg_pkg::STORED_STEP_DIR)
		|=> state_q == stepper_cfg_pkg::ST_RUN && mode_q == stepper_cfg_pkg::STEP_DIR_DRIVER_MODE)
		else $error("default normal mode not entered");
	a_ext_step: assert property ((state_q == stepper_cfg_pkg::ST_RUN && mode_q == stepper_cfg_pkg::STEP_DIR_DRIVER_MODE
		&& step_rise && !ctrl_q[stepper_cfg_pkg::CTRL_HOLD_BIT]) |=> o_step_pulse)
		else $error("external step edge lost");
	a_enable_gate: assert property (clean[stepper_cfg_pkg::IN_ENABLE_N] |=> !o_motor_enable)
		else $error("drive on while enable inactive");
	a_dir_hold: assert property (!pulse_q |-> $stable(o_direction))
		else $error("direction changed without a step");
	a_pos_step: assert property (pulse_q |-> pos_q != $past(pos_q))
		else $error("position did not move on a step");
	a_store_once: assert property (s_setup_exit |=> o_store_valid ##1 (!o_store_valid and s_stored_forever))
		else $error("setup store not single and final");
	a_invalid_off: assert property (state_q == stepper_cfg_pkg::ST_INVALID |=> !o_motor_enable && !o_step_pulse)
		else $error("outputs active in invalid state");
	a_latch_once: assert property (state_q != stepper_cfg_pkg::ST_BOOT |=> $stable(mode_q))
		else $error("mode changed after power-up latch");

endmodule

`default_nettype wire

// ### bench/step_source.sv
/*
 * Model of the external step/direction controller at the connector.
 * Assumes one shared clock; a pulse on i_fire asks for one step pulse.
 */
`default_nettype none
module step_source (
	input wire logic i_clock,
	input wire logic i_fire,
	input wire logic i_dir,
	output logic o_step,
	output logic o_dir,
	output logic o_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lines rest high, as the pull-ups would hold them when left open.
	initial begin
		o_step = 1'b1;
		o_dir = 1'b1;
		o_busy = 1'b0;
	end
	// Direction is set well before any step edge, so it is never ambiguous.
	always @(posedge i_clock) begin
		o_dir <= i_dir;
	end
	// Low and high times of one microsecond each, the shortest the pin allows.
	always @(posedge i_clock) begin
		if (i_fire && !o_busy) begin
			o_busy <= 1'b1;
			repeat (25) @(posedge i_clock);
			o_step <= 1'b0;
			repeat (25) @(posedge i_clock);
			o_step <= 1'b1;
			repeat (25) @(posedge i_clock);
			o_busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
/*
 * Self-checking bench for the power-up mode and configuration block.
 * Assumes the settle count is shortened to 8 cycles and a 25 MHz clock.
 */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0, i_rstn = 1'b0, i_drive_enable_n = 1'b0, i_start_stop_in = 1'b1, i_gen_step_tick = 1'b0;
	logic [5:0] i_config_switch = 6'h00;
	stepper_cfg_pkg::normal_mode_t i_stored_mode = stepper_cfg_pkg::STORED_STEP_DIR;
	logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0, fire = 1'b0, dir_req = 1'b1;
	logic [3:0] i_wb_adr = 4'h0, i_wb_sel = 4'h0;
	logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
	logic o_wb_ack, o_motor_enable, o_step_pulse, o_direction, o_gen_run, o_store_valid, step_w, dir_w, busy;
	stepper_cfg_pkg::resolution_t o_resolution;
	stepper_cfg_pkg::op_mode_t o_mode;
	stepper_cfg_pkg::freq_range_t o_gen_range;
	stepper_cfg_pkg::store_t o_store;
	int fail_count = 0, check_count = 0, step_count = 0, store_count = 0, cycles = 0;
	stepper_powerup_mode_config #(.SWITCH_SETTLE_CYCLES(8), .CTRL_FILTER_CYCLES(5)) uut (.i_clock(i_clock),
		.i_rstn(i_rstn), .i_config_switch(i_config_switch), .i_drive_enable_n(i_drive_enable_n),
		.i_step_in(step_w), .i_direction_in(dir_w), .i_start_stop_in(i_start_stop_in),
		.i_gen_step_tick(i_gen_step_tick), .i_stored_mode(i_stored_mode), .i_wb_cyc(i_wb_cyc),
		.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel),
		.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_motor_enable(o_motor_enable), .o_step_pulse(o_step_pulse),
		.o_direction(o_direction), .o_resolution(o_resolution), .o_mode(o_mode), .o_gen_range(o_gen_range),
		.o_gen_run(o_gen_run), .o_store_valid(o_store_valid), .o_store(o_store));
	step_source partner (.i_clock(i_clock), .i_fire(fire), .i_dir(dir_req), .o_step(step_w), .o_dir(dir_w),
		.o_busy(busy));
	// ****************************************************************
	// Clock, monitors and shared tasks
	// ****************************************************************
	initial begin
		forever #20 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		step_count += (o_step_pulse === 1'b1);
		store_count += (o_store_valid === 1'b1);
		cycles++;
		if (cycles == 30000) begin
			fail_count++;
			$display("Error at %0t: run timed out", $time);
			complete_run();
		end
	end
	task automatic complete_run();
		$display("Counts: %0d checks, %0d mismatches", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge i_clock);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_adr <= adr;
		i_wb_dat <= wd;
		i_wb_sel <= 4'hf;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_wb_ack !== 1'b1);
		rd = o_wb_dat;
		check(n, 2, "bus answer latency");
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		i_wb_we <= 1'b0;
	endtask
	task automatic boot(input logic [5:0] sw, input logic [1:0] sm);
		@(posedge i_clock);
		i_rstn <= 1'b0;
		i_config_switch <= sw;
		i_stored_mode <= stepper_cfg_pkg::normal_mode_t'(sm);
		repeat (5) @(posedge i_clock);
		i_rstn <= 1'b1;
		repeat (40) @(posedge i_clock);
	endtask
	task automatic set_sw(input logic [5:0] v);
		@(posedge i_clock);
		i_config_switch <= v;
		repeat (20) @(posedge i_clock);
	endtask
	task automatic step_once(input logic d);
		int n;
		dir_req <= d;
		repeat (3) @(posedge i_clock);
		fire <= 1'b1;
		@(posedge i_clock);
		fire <= 1'b0;
		@(posedge i_clock);
		for (n = 0; n < 200 && busy !== 1'b0; n++) @(posedge i_clock);
		repeat (2) @(posedge i_clock);
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_normal();
		int k, s;
		boot(6'h00, 2'h0);
		check(o_mode, stepper_cfg_pkg::STEP_DIR_DRIVER_MODE, "shipped boot mode");
		check(o_motor_enable, 1'b1, "enable low drives");
		for (k = 0; k < 4; k++) begin
			set_sw({k[1], k[0], 4'h0});
			check(o_resolution, {k[0], k[1]}, "microstep decode");
		end
		wb(1'b0, stepper_cfg_pkg::ADDR_CTRL, 32'h0);
		check(rd, stepper_cfg_pkg::CTRL_RESET, "control reset");
		wb(1'b0, 4'hc, 32'h0);
		check(rd, 32'h0, "unmapped read");
		set_sw(6'h30);
		wb(1'b0, stepper_cfg_pkg::ADDR_POSITION, 32'h0);
		s = rd[15:0];
		step_once(1'b0);
		check(step_count, 1, "external step pulse");
		wb(1'b0, stepper_cfg_pkg::ADDR_POSITION, 32'h0);
		check(rd[15:0], 16'(s + 16), "full step advance");
		dir_req <= 1'b1;
		repeat (20) @(posedge i_clock);
		check(o_direction, 1'b0, "direction held");
		step_once(1'b1);
		check(o_direction, 1'b1, "direction applied");
		wb(1'b0, stepper_cfg_pkg::ADDR_POSITION, 32'h0);
		check(rd[15:0], 16'(s), "step back");
		i_gen_step_tick <= 1'b1;
		@(posedge i_clock);
		i_gen_step_tick <= 1'b0;
		repeat (3) @(posedge i_clock);
		check(step_count, 2, "tick ignored");
		i_drive_enable_n <= 1'b1;
		set_sw(6'h00);
		check(o_motor_enable, 1'b0, "enable high stops drive");
		wb(1'b1, stepper_cfg_pkg::ADDR_CTRL, 32'h1);
		step_once(1'b0);
		wb(1'b0, stepper_cfg_pkg::ADDR_POSITION, 32'h0);
		check(rd[15:0], 16'(s + 1), "counted while off");
		wb(1'b1, stepper_cfg_pkg::ADDR_CTRL, 32'h3);
		step_once(1'b0);
		check(step_count, 3, "hold blocks steps");
		wb(1'b1, stepper_cfg_pkg::ADDR_CTRL, 32'h0);
		i_drive_enable_n <= 1'b0;
		$display("Test normal done");
	endtask
	task automatic t_codes();
		logic [5:0] sw [8];
		logic [1:0] sm [8];
		logic [2:0] md [8];
		int i;
		sw = '{6'h08, 6'h09, 6'h01, 6'h00, 6'h00, 6'h00, 6'h02, 6'h38};
		sm = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
		md = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h7, 3'h1};
		for (i = 0; i < 8; i++) begin
			boot(sw[i], sm[i]);
			check(o_mode, md[i], "power-up mode");
			if (md[i] == 3'h7) check(o_motor_enable, 1'b0, "invalid stays off");
		end
		$display("Test codes done");
	endtask
	task automatic t_range();
		int k, n;
		boot(6'h09, 2'h0);
		for (k = 0; k < 4; k++) begin
			set_sw({3'h1, k[1], k[0], 1'b1});
			check(o_gen_range, {k[1], k[0]}, "range decode");
		end
		set_sw(6'h0d);
		n = store_count;
		set_sw(6'h05);
		check(store_count, n + 1, "store on exit");
		check(o_store, {stepper_cfg_pkg::STORED_ADJUSTABLE, stepper_cfg_pkg::MID_FREQ_RANGE}, "stored");
		check(o_motor_enable, 1'b0, "dead after store");
		set_sw(6'h0d);
		set_sw(6'h05);
		check(store_count, n + 1, "single store");
		$display("Test range done");
	endtask
	task automatic t_gen();
		int n;
		boot(6'h00, 2'h1);
		check(o_gen_run, 1'b0, "stopped");
		i_start_stop_in <= 1'b0;
		repeat (20) @(posedge i_clock);
		check(o_gen_run, 1'b1, "started");
		n = step_count;
		i_gen_step_tick <= 1'b1;
		@(posedge i_clock);
		i_gen_step_tick <= 1'b0;
		repeat (3) @(posedge i_clock);
		check(step_count, n + 1, "generator step");
		i_start_stop_in <= 1'b1;
		$display("Test generator done");
	endtask
	initial begin
		t_normal();
		t_codes();
		t_range();
		t_gen();
		complete_run();
	end
endmodule
`default_nettype wire
